// *** dbac_consts.svh ***
// Purpose: offsets, field positions, reset values for the bridge/arbiter config bank
// Assumes: 32-bit apb data, one aligned word per register
// Notes: included by bare name
`ifndef DBAC_CONSTS_SVH
`define DBAC_CONSTS_SVH
`define DBAC_OFF_SIZE        12'h000
`define DBAC_OFF_BRIDGE      12'h004
`define DBAC_OFF_CORRECT     12'h008
`define DBAC_OFF_WEIGHT      12'h00c
`define DBAC_OFF_BASE        12'h010
`define DBAC_RST_SIZE        4'h1
`define DBAC_RST_BASE        16'ha000
`define DBAC_RST_BRIDGE      8'hbc
`define DBAC_RST_CORRECT     2'h0
`define DBAC_RST_WEIGHT      5'h00
`define DBAC_CODE_NONE       4'h0
`define DBAC_SIZE_MSB        3
`define DBAC_CPU_MAP_LSB     16
`define DBAC_DMA_MAP_LSB     12
`define DBAC_BUF_LEN_BIT     7
`define DBAC_CPU_REN_BIT     5
`define DBAC_CPU_WEN_BIT     4
`define DBAC_DMA_REN_BIT     3
`define DBAC_DMA_WEN_BIT     2
`define DBAC_PERIPH_DMA_MASTER_LSB        25
`define DBAC_FAB1_LSB        20
`define DBAC_FAB0_LSB        15
`define DBAC_BASE_SHIFT      15
`define DBAC_LEN_SHORT       6'h10
`define DBAC_LEN_LONG        6'h20
`endif

// *** dbac_pkg.sv ***
// Purpose: shared types for the bridge/arbiter config bank
// Assumes: nothing beyond the consts header
// Notes: types only; numbers live in dbac_consts.svh
package dbac_pkg;
  typedef logic [3:0]  dbac_code_t;
  typedef logic [4:0]  dbac_wfield_t;
  typedef logic [5:0]  dbac_weight_t;
  typedef logic [31:0] dbac_word_t;
endpackage

// *** dbac_config_regs.sv ***
// Purpose: apb register bank steering ddr bridge, sram correction and arbiter weights
// Assumes: single clock, synchronous active-low reset, zero-wait apb slave
// Notes: unmapped addresses read zero, writes ignored, pslverr low
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dbac_consts.svh"

// Contract
// - 4-bit size code, reset one, zero none
// - region is 64 KB times 2^(N-1)
// - cpu master map mode bits 19:16
// - fast dma map mode bits 15:12
// - bit 7 buffer length 16/32 bytes
// - bit 5 cpu read buffer enable
// - bit 4 cpu write combine enable
// - bit 3 fast dma read buffer enable
// - bit 2 fast dma write combine enable
// - bit 1 sram bank1 correction enable
// - bit 0 sram bank0 correction enable
// - periph dma weight bits 29:25
// - fabric port one weight bits 24:20
// - fabric port zero weight bits 19:15
// - weight field zero means 32
// - compare base bits with upper address bits
module dbac_config_regs #(
  parameter int ADDR_W = 12
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [ADDR_W-1:0]     i_paddr,
  input  wire logic [31:0]           i_pwdata,
  input  wire logic [31:0]           i_bus_addr,
  output logic                       o_pready,
  output logic                       o_pslverr,
  output dbac_pkg::dbac_word_t       o_prdata,
  output dbac_pkg::dbac_code_t       o_uncached_region_size_code,
  output logic [15:0]                o_uncached_region_base,
  output logic [31:0]                o_uncached_region_bytes,
  output logic                       o_uncached_hit,
  output dbac_pkg::dbac_code_t       o_cpu_master_ddr_map_mode,
  output dbac_pkg::dbac_code_t       o_fast_dma_ddr_map_mode,
  output logic [5:0]                 o_bridge_buffer_length,
  output logic                       o_cpu_read_buffer_enable,
  output logic                       o_cpu_write_combine_enable,
  output logic                       o_fast_dma_read_buffer_enable,
  output logic                       o_fast_dma_write_combine_enable,
  output logic                       o_sram_bank1_correct_enable,
  output logic                       o_sram_bank0_correct_enable,
  output dbac_pkg::dbac_weight_t     o_periph_dma_arb_weight,
  output dbac_pkg::dbac_weight_t     o_fabric_port_one_arb_weight,
  output dbac_pkg::dbac_weight_t     o_fabric_port_zero_arb_weight
);
  import dbac_pkg::*;

  // elaboration guard: the base word needs five address bits, and more
  // than twelve would alias through the 12-bit compare below
  if (ADDR_W < 5 || ADDR_W > 12)
  begin : g_bad_addr_w
    $error("ADDR_W must be 5 to 12");
  end

  // stored fields; only documented bits have flops, bar bridge bits 6, 1 and 0, which writes hold at zero, so reserved bits cannot matter
  dbac_code_t   size_code_r;
  logic [15:0]  base_r;
  logic [7:0]   bridge_r;
  logic [1:0]   correct_r;
  dbac_wfield_t w_periph_dma_master_r;
  dbac_wfield_t w_fab1_r;
  dbac_wfield_t w_fab0_r;
  dbac_word_t   rdata_r;

  // address decode, apb write taken in the access phase
  wire logic [11:0] addr12   = 12'(i_paddr);
  wire logic        access   = i_psel & i_penable;
  wire logic        wr_en    = access & i_pwrite;
  wire logic        sel_size = (addr12 == `DBAC_OFF_SIZE);
  wire logic        sel_brg  = (addr12 == `DBAC_OFF_BRIDGE);
  wire logic        sel_cor  = (addr12 == `DBAC_OFF_CORRECT);
  wire logic        sel_wgt  = (addr12 == `DBAC_OFF_WEIGHT);
  wire logic        sel_base = (addr12 == `DBAC_OFF_BASE);

  // writes keep only the defined bits of each word
  wire logic [7:0]  bridge_mask = 8'hbc;
  wire logic [7:0]  bridge_wr   = i_pwdata[7:0] & bridge_mask;

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      size_code_r <= `DBAC_RST_SIZE;
      base_r      <= `DBAC_RST_BASE;
      bridge_r    <= `DBAC_RST_BRIDGE;
      correct_r   <= `DBAC_RST_CORRECT;
      w_periph_dma_master_r    <= `DBAC_RST_WEIGHT;
      w_fab1_r    <= `DBAC_RST_WEIGHT;
      w_fab0_r    <= `DBAC_RST_WEIGHT;
    end
    else if (wr_en)
    begin
      if (sel_size)
        size_code_r <= i_pwdata[`DBAC_SIZE_MSB:0];
      if (sel_base)
        base_r <= i_pwdata[15:0];
      if (sel_brg)
        bridge_r <= bridge_wr;
      if (sel_cor)
        correct_r <= i_pwdata[1:0];
      if (sel_wgt)
      begin
        w_periph_dma_master_r <= i_pwdata[`DBAC_PERIPH_DMA_MASTER_LSB +: 5];
        w_fab1_r <= i_pwdata[`DBAC_FAB1_LSB +: 5];
        w_fab0_r <= i_pwdata[`DBAC_FAB0_LSB +: 5];
      end
    end
  end

  // map mode fields share the bridge word but sit above the byte of flags
  dbac_code_t cpu_map_r;
  dbac_code_t dma_map_r;
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      cpu_map_r <= 4'h0;
      dma_map_r <= 4'h0;
    end
    else if (wr_en && sel_brg)
    begin
      cpu_map_r <= i_pwdata[`DBAC_CPU_MAP_LSB +: 4];
      dma_map_r <= i_pwdata[`DBAC_DMA_MAP_LSB +: 4];
    end
  end

  // read words; reserved bits come back zero
  wire dbac_word_t rd_size = {28'h0000000, size_code_r};
  wire dbac_word_t rd_brg  = {12'h000, cpu_map_r, dma_map_r, 4'h0, bridge_r};
  wire dbac_word_t rd_cor  = {30'h00000000, correct_r};
  wire dbac_word_t rd_wgt  = {2'h0, w_periph_dma_master_r, w_fab1_r, w_fab0_r, 15'h0000};
  wire dbac_word_t rd_base = {16'h0000, base_r};
  wire dbac_word_t rd_mux  = sel_size ? rd_size :
                             sel_brg  ? rd_brg  :
                             sel_cor  ? rd_cor  :
                             sel_wgt  ? rd_wgt  :
                             sel_base ? rd_base : 32'h00000000;

  // read data registered in the setup cycle so it is ready in the access phase
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
      rdata_r <= 32'h00000000;
    else if (i_psel && !i_penable && !i_pwrite)
      rdata_r <= rd_mux;
  end

  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_prdata  = rdata_r;

  // weight decode: field zero stands for the top weight
  function automatic dbac_weight_t weight_of(input dbac_wfield_t f);
    weight_of = (f == 5'h00) ? 6'h20 : {1'b0, f};
  endfunction

  assign o_periph_dma_arb_weight       = weight_of(w_periph_dma_master_r);
  assign o_fabric_port_one_arb_weight  = weight_of(w_fab1_r);
  assign o_fabric_port_zero_arb_weight = weight_of(w_fab0_r);

  // region length in bytes: 64 KB shifted by code minus one, zero for no region
  wire logic [4:0]  size_shift = 5'(size_code_r) + 5'd15;
  assign o_uncached_region_bytes = (size_code_r == `DBAC_CODE_NONE) ? 32'h0 :
                                   (32'h1 << size_shift);

  // hit compare: upper address bits [31:N+15] against base bits [15:N-1]
  wire logic [31:0] hi_mask = ~(o_uncached_region_bytes - 32'h1);
  // base bit k lines up with address bit k+16, so base[N-1] meets addr[N+15];
  // any further shift would drop base bit 15 and misplace every window
  wire logic [31:0] base_ext = {base_r, 16'h0000};
  wire logic [31:0] addr_hi = i_bus_addr & hi_mask;
  wire logic [31:0] base_hi = base_ext & hi_mask;
  assign o_uncached_hit = (size_code_r != `DBAC_CODE_NONE) &&
                          (addr_hi[31:0] == base_hi[31:0]);

  assign o_uncached_region_size_code     = size_code_r;
  assign o_uncached_region_base          = base_r;
  assign o_cpu_master_ddr_map_mode       = cpu_map_r;
  assign o_fast_dma_ddr_map_mode         = dma_map_r;
  assign o_bridge_buffer_length          = bridge_r[`DBAC_BUF_LEN_BIT] ?
                                           `DBAC_LEN_LONG : `DBAC_LEN_SHORT;
  assign o_cpu_read_buffer_enable        = bridge_r[`DBAC_CPU_REN_BIT];
  assign o_cpu_write_combine_enable      = bridge_r[`DBAC_CPU_WEN_BIT];
  assign o_fast_dma_read_buffer_enable   = bridge_r[`DBAC_DMA_REN_BIT];
  assign o_fast_dma_write_combine_enable = bridge_r[`DBAC_DMA_WEN_BIT];
  assign o_sram_bank1_correct_enable     = correct_r[1];
  assign o_sram_bank0_correct_enable     = correct_r[0];

  // checks on register effects
  a_size_reset: assert property (@(posedge i_clock)
    !i_rstn |=> size_code_r == 4'h1)
    else $error("size code reset wrong");
  a_region_len: assert property (@(posedge i_clock) disable iff (!i_rstn)
    size_code_r == 4'hf |-> o_uncached_region_bytes == 32'h40000000)
    else $error("code 15 not 1 GB");
  a_map_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_brg |=> cpu_map_r == $past(i_pwdata[19:16])
                         && dma_map_r == $past(i_pwdata[15:12]))
    else $error("map mode write lost");
  a_buf_len: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_brg && i_pwdata[7] |=> o_bridge_buffer_length == 6'h20)
    else $error("buffer length not 32");
  a_bridge_reset: assert property (@(posedge i_clock)
    !i_rstn |=> o_cpu_read_buffer_enable && o_cpu_write_combine_enable
      && o_fast_dma_read_buffer_enable && o_fast_dma_write_combine_enable)
    else $error("bridge enables not set at reset");
  a_edac_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_cor |=> o_sram_bank1_correct_enable == $past(i_pwdata[1])
      && o_sram_bank0_correct_enable == $past(i_pwdata[0]))
    else $error("correction enable write lost");
  a_weight_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_wgt && i_pwdata[29:25] == 5'h00
      |=> o_periph_dma_arb_weight == 6'h20)
    else $error("zero weight not 32");
  a_weight_fab: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_wgt && i_pwdata[24:20] == 5'h03 && i_pwdata[19:15] == 5'h1f
      |=> o_fabric_port_one_arb_weight == 6'h03
          && o_fabric_port_zero_arb_weight == 6'h1f)
    else $error("fabric weight wrong");
  a_no_hit: assert property (@(posedge i_clock) disable iff (!i_rstn)
    size_code_r == 4'h0 |-> !o_uncached_hit)
    else $error("hit with no region");
  // only a read access holds bridge data; a write leaves older read data up
  a_rsvd_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_psel && i_penable && !i_pwrite && sel_brg
      |-> o_prdata[31:20] == 12'h000 && o_prdata[11:8] == 4'h0
          && o_prdata[6] == 1'b0 && o_prdata[1:0] == 2'h0)
    else $error("reserved bits read nonzero");

  // writes land in the cycle after the access phase
  a_size_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_size |=> size_code_r == $past(i_pwdata[3:0]))
    else $error("size code write lost");
  a_bridge_flags: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_brg |=> o_cpu_read_buffer_enable == $past(i_pwdata[5])
      && o_cpu_write_combine_enable == $past(i_pwdata[4])
      && o_fast_dma_read_buffer_enable == $past(i_pwdata[3])
      && o_fast_dma_write_combine_enable == $past(i_pwdata[2]))
    else $error("bridge enable write lost");
  a_base_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_base |=> base_r == $past(i_pwdata[15:0]))
    else $error("region base write lost");
  a_weight_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_wgt |=> w_periph_dma_master_r == $past(i_pwdata[29:25])
      && w_fab1_r == $past(i_pwdata[24:20]) && w_fab0_r == $past(i_pwdata[19:15]))
    else $error("weight field write lost");

  // a reset puts every field back, whatever was written before
  a_map_reset: assert property (@(posedge i_clock)
    !i_rstn |=> o_cpu_master_ddr_map_mode == 4'h0 && o_fast_dma_ddr_map_mode == 4'h0)
    else $error("map modes not zero after reset");
  a_edac_reset: assert property (@(posedge i_clock)
    !i_rstn |=> !o_sram_bank1_correct_enable && !o_sram_bank0_correct_enable)
    else $error("correction enabled after reset");
  a_weight_reset: assert property (@(posedge i_clock)
    !i_rstn |=> o_periph_dma_arb_weight == 6'h20 && o_fabric_port_one_arb_weight == 6'h20
      && o_fabric_port_zero_arb_weight == 6'h20)
    else $error("weights not 32 after reset");

  // region window, buffer length and weight range as the far side sees them
  a_code1_len: assert property (@(posedge i_clock) disable iff (!i_rstn)
    size_code_r == 4'h1 |-> o_uncached_region_bytes == 32'h00010000)
    else $error("code 1 not 64 KB");
  a_len_short: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && sel_brg && !i_pwdata[7] |=> o_bridge_buffer_length == 6'h10)
    else $error("buffer length not 16");
  a_weight_range: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_periph_dma_arb_weight inside {[6'h01:6'h20]}
      && o_fabric_port_one_arb_weight inside {[6'h01:6'h20]}
      && o_fabric_port_zero_arb_weight inside {[6'h01:6'h20]})
    else $error("weight outside 1 to 32");
  a_hit_small: assert property (@(posedge i_clock) disable iff (!i_rstn)
    size_code_r == 4'h1 && i_bus_addr[31:16] == base_r |-> o_uncached_hit)
    else $error("64 KB window missed");
  a_hit_whole: assert property (@(posedge i_clock) disable iff (!i_rstn)
    size_code_r == 4'hf |-> o_uncached_hit == (i_bus_addr[31:30] == base_r[15:14]))
    else $error("1 GB window compare wrong");

  // unmapped writes and reserved bits must not reach any field
  a_unmapped_quiet: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_en && !(sel_size || sel_brg || sel_cor || sel_wgt || sel_base)
      |=> $stable(size_code_r) && $stable(base_r) && $stable(bridge_r)
          && $stable(correct_r) && $stable({w_periph_dma_master_r, w_fab1_r, w_fab0_r})
          && $stable({cpu_map_r, dma_map_r}))
    else $error("unmapped write changed a field");
  a_rsvd_weight: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_psel && i_penable && !i_pwrite && sel_wgt
      |-> o_prdata[31:30] == 2'h0 && o_prdata[14:0] == 15'h0000)
    else $error("weight word reserved bits nonzero");
  a_rsvd_correct: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_psel && i_penable && !i_pwrite && sel_cor |-> o_prdata[31:2] == 30'h00000000)
    else $error("correction word reserved bits nonzero");

  c_bridge_write: cover property (@(posedge i_clock) wr_en && sel_brg);
  c_weight_write: cover property (@(posedge i_clock) wr_en && sel_wgt);
  c_hit_seen: cover property (@(posedge i_clock) o_uncached_hit && size_code_r == 4'h3);
  c_read_size: cover property (@(posedge i_clock) access && !i_pwrite && sel_size);
  // a stray write must be seen to prove the bank ignores it
  c_unmapped_write: cover property (@(posedge i_clock)
    wr_en && !(sel_size || sel_brg || sel_cor || sel_wgt || sel_base));
endmodule

// *** dbac_bridge_model.sv ***
// Purpose: far-side bridge address source for the config bank bench
// Assumes: single clock shared with the bank
// Notes: presents one registered access address per cycle
`timescale 1ns/1ps
module dbac_bridge_model (
  input  wire logic        i_clock,
  input  wire logic [31:0] i_target,
  output logic      [31:0] o_bus_addr
);
  // address flops like a bus address phase, so hit is judged a cycle later
  always_ff @(posedge i_clock)
    o_bus_addr <= i_target;
endmodule

// *** dbac_config_regs_bench.sv ***
// Purpose: self-checking bench for the bridge/arbiter config bank
// Assumes: apb slave, offsets from dbac_consts.svh
// Notes: random words from a fixed seed, with all-zero and all-one corners
`timescale 1ns/1ps
`include "dbac_consts.svh"
module dbac_config_regs_bench;
  import dbac_pkg::*;
  logic        clk, rstn, psel, pen, pwr, pready, pslverr, hit;
  logic        cr, cw, dr, dw, b1, b0;
  logic [11:0] paddr;
  logic [31:0] pwdata, target, baddr, q, w, ta, bytes, prdata;
  logic [15:0] base;
  logic [5:0]  blen, wp, w1, w0;
  logic [3:0]  code, cmap, dmap;
  logic [31:0] sh [5];
  logic [31:0] mk [5] = '{32'hf, 32'hff0bc, 32'h3, 32'h3fff8000, 32'hffff};
  int          mismatches, n_tests, i, j, c;
  dbac_config_regs uut (.i_clock(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_bus_addr(baddr),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .o_uncached_region_size_code(code), .o_uncached_region_base(base),
    .o_uncached_region_bytes(bytes), .o_uncached_hit(hit),
    .o_cpu_master_ddr_map_mode(cmap), .o_fast_dma_ddr_map_mode(dmap),
    .o_bridge_buffer_length(blen), .o_cpu_read_buffer_enable(cr),
    .o_cpu_write_combine_enable(cw), .o_fast_dma_read_buffer_enable(dr),
    .o_fast_dma_write_combine_enable(dw), .o_sram_bank1_correct_enable(b1),
    .o_sram_bank0_correct_enable(b0), .o_periph_dma_arb_weight(wp),
    .o_fabric_port_one_arb_weight(w1), .o_fabric_port_zero_arb_weight(w0));
  dbac_bridge_model far (.i_clock(clk), .i_target(target), .o_bus_addr(baddr));
  // expected weight and region size, worked out independently
  function automatic logic [31:0] wt(input logic [4:0] f);
    return (f == 5'h00) ? 32'h20 : {27'h0, f};
  endfunction
  function automatic logic [31:0] nb(input logic [3:0] k);
    return (k == 4'h0) ? 32'h0 : 32'h1 << (k + 15);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    chk("pready", {31'h0, pready}, 32'h1);
    q = prdata;
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask
  // compare every config output with the shadow copy
  task chk_out;
    chk("code", {28'h0, code}, sh[0] & 32'hf);
    chk("bytes", bytes, nb(sh[0][3:0]));
    chk("cmap", {28'h0, cmap}, {28'h0, sh[1][19:16]});
    chk("dmap", {28'h0, dmap}, {28'h0, sh[1][15:12]});
    chk("blen", {26'h0, blen}, sh[1][7] ? 32'h20 : 32'h10);
    chk("cr", {31'h0, cr}, {31'h0, sh[1][5]});
    chk("cw", {31'h0, cw}, {31'h0, sh[1][4]});
    chk("dr", {31'h0, dr}, {31'h0, sh[1][3]});
    chk("dw", {31'h0, dw}, {31'h0, sh[1][2]});
    chk("b1", {31'h0, b1}, {31'h0, sh[2][1]});
    chk("b0", {31'h0, b0}, {31'h0, sh[2][0]});
    chk("wp", {26'h0, wp}, wt(sh[3][29:25]));
    chk("w1", {26'h0, w1}, wt(sh[3][24:20]));
    chk("w0", {26'h0, w0}, wt(sh[3][19:15]));
    chk("base", {16'h0, base}, sh[4]);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // watchdog: the whole run needs far fewer than 5000 cycles
  initial
  begin
    #125000;
    mismatches++;
    test_done;
  end
  initial
  begin
    {rstn, psel, pen, pwr, paddr, pwdata, target} = '0;
    sh = '{32'h1, 32'hbc, 32'h0, 32'h0, 32'ha000};
    void'($urandom(29387));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    // reset values, then random words with zero and all-one corners
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset read", q, sh[i]);
    end
    chk_out;
    for (j = 0; j < 12; j++)
    begin
      for (i = 0; i < 5; i++)
      begin
        w = (j == 0) ? 32'h0 : (j == 1) ? 32'hffffffff :
            (j == 2) ? 32'h003f8000 : $urandom;
        apb(1'b1, 12'(i * 4), w);
        sh[i] = w & mk[i];
        apb(1'b0, 12'(i * 4), 32'h0);
        chk("readback", q, sh[i]);
      end
      chk_out;
    end
    // reset in mid-run must restore every field
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    sh = '{32'h1, 32'hbc, 32'h0, 32'h0, 32'ha000};
    #1;
    chk_out;
    // region hit over every size code, inside and just outside
    for (c = 0; c < 16; c++)
    begin
      w = $urandom;
      apb(1'b1, `DBAC_OFF_BASE, w);
      apb(1'b1, `DBAC_OFF_SIZE, 32'(c));
      sh[4] = w & mk[4];
      sh[0] = 32'(c);
      chk("bytes", bytes, nb(4'(c)));
      for (j = 0; j < 2; j++)
      begin
        ta = ({w[15:0], 16'h0} & ~(nb(4'(c)) - 1)) | ($urandom & (nb(4'(c)) - 1));
        if (j == 1)
          ta[c + 15] = ~ta[c + 15];
        @(posedge clk);
        target <= ta;
        repeat (2) @(posedge clk);
        #1;
        chk("hit", {31'h0, hit}, {31'h0, c != 0 && j == 0});
      end
    end
    // unmapped place: reads zero and leaves the bank alone
    apb(1'b1, 12'h014, 32'hffffffff);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", q, 32'h0);
    chk_out;
    test_done;
  end
endmodule
